// file: adc_ctrl_defines.svh
// Register offsets, field positions, reset values and timing counts
// for the converter control block. Assumes a 25 MHz bus clock.
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_STATUS_CONTROL_ONE 12'h000
`define OFS_STATUS_CONTROL_TWO 12'h004
`define OFS_RESULT_HIGH 12'h008
`define OFS_RESULT_LOW 12'h00c
`define OFS_COMPARE_VALUE_HIGH 12'h010
`define OFS_COMPARE_VALUE_LOW 12'h014
`define OFS_CONFIGURATION 12'h018

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_COMPLETION_FLAG 7
`define BIT_CONVERSION_ACTIVE 7
`define BIT_TRIGGER_SOURCE 6
`define BIT_COMPARE_ENABLE 5
`define BIT_COMPARE_GE 4
`define MODE_MSB 3
`define MODE_LSB 2

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define RST_CHANNEL 5'h1f
`define RST_MODE 2'h0
`define RST_COMPARE 8'h00
`define CHANNEL_LAST_INPUT 5'h1b
`define CHANNEL_RESERVED 5'h1c
`define CHANNEL_REF_HIGH 5'h1d
`define CHANNEL_REF_LOW 5'h1e
`define CHANNEL_OFF 5'h1f
`define MODE_EIGHT_BIT 2'h0
`define MODE_TEN_BIT 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define CONV_TIME_NS 1000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: adc_ctrl_pkg.sv
// Types shared by the converter control block and its conversion engine.
// Assumes the constants header is included where numbers are needed.
package adc_ctrl_pkg;

  typedef enum logic [1:0]
  {
    ENGINE_IDLE = 2'b01,
    ENGINE_CONVERT = 2'b10
  } engine_state_e;

  typedef logic [9:0] result_t;
  typedef logic [4:0] channel_t;

endpackage

// file: conv_if.sv
// Handshake between the register side and the conversion engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface conv_if;
  import adc_ctrl_pkg::*;
  logic start;
  logic abort;
  logic busy;
  logic done;
  result_t result;

  modport ctrl
  (
    output start,
    output abort,
    input busy,
    input done,
    input result
  );

  modport engine
  (
    input start,
    input abort,
    output busy,
    output done,
    output result
  );
endinterface

// file: conv_engine.sv
// Conversion engine: times one conversion and captures the sample.
// Assumes sample_data is stable and right-justified at the end of a conversion.
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module conv_engine
(
  input wire logic clk,
  input wire logic reset,
  input wire adc_ctrl_pkg::result_t sample_data,
  conv_if.engine conv
);
  import adc_ctrl_pkg::*;

  localparam logic [7:0] CONV_LAST = 8'(`CONV_CYCLES - 1);

  engine_state_e state;
  logic [7:0] count;

  assign conv.busy = (state == ENGINE_CONVERT);

  // Start wins over abort so a restart after abort never drops a cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state <= ENGINE_IDLE;
    else
    begin
      case (state)
        ENGINE_IDLE:
          if (conv.start)
            state <= ENGINE_CONVERT;
        ENGINE_CONVERT:
          if (conv.start)
            state <= ENGINE_CONVERT;
          else if (conv.abort || count == 8'h00)
            state <= ENGINE_IDLE;
        default:
          state <= ENGINE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      count <= 8'h00;
    else if (conv.start)
      count <= CONV_LAST;
    else if (state == ENGINE_CONVERT && count != 8'h00)
      count <= count - 8'h01;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      conv.done <= 1'b0;
      conv.result <= 10'h000;
    end
    else
    begin
      conv.done <= (state == ENGINE_CONVERT) && !conv.start && !conv.abort
        && count == 8'h00;
      if ((state == ENGINE_CONVERT) && !conv.start && !conv.abort && count == 8'h00)
        conv.result <= sample_data;
    end
  end
endmodule

// file: adc_trigger_result_compare_regs.sv
// Register side of the converter: trigger, compare and result interlock.
// Assumes an APB master on clk and a conversion engine delivering results.
//
// Function
// [RULE_01] Channel codes pick inputs 0..27, references, reserved code, or power down.
// [RULE_02] Conversion-active flag is high from conversion start until finish or abort.
// [RULE_03] Trigger select bit chooses software write or hardware trigger start.
// [RULE_04] Software writes zero to the two low reserved bits of control two.
// [RULE_05] Compare enable bit turns the automatic compare on or off.
// [RULE_06] Polarity bit: clear means less than, set means greater or equal.
// [RULE_07] Ten-bit mode puts result bits nine and eight in result-high low bits.
// [RULE_08] Eight-bit mode keeps result-high upper result bits at zero.
// [RULE_09] Result-low holds low eight bits, or the whole eight-bit result.
// [RULE_10] Results load on every completion unless enabled compare fails.
// [RULE_11] Ten-bit result-high read locks results until result-low is read.
// [RULE_12] A conversion finishing while locked is thrown away.
// [RULE_13] Eight-bit mode has no read lock between result registers.
// [RULE_14] Changing resolution invalidates held results.
// [RULE_15] Compare-high bits meet result bits nine and eight in ten-bit compare.
// [RULE_16] Eight-bit compare ignores the compare-high register.
// [RULE_17] Compare-low bits meet the low eight result bits in both modes.
// [RULE_18] Completion flag sets at end if compare passes; clears on write or read.
// [RULE_19] Writing control one aborts, and restarts unless channel is all ones; the code restarts only with software trigger selected.
// [RULE_20] Resolution code 00 is eight-bit, 10 is ten-bit, others reserved.
// [RULE_21] Hardware trigger is synchronised and acts on its rising edge.
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module adc_trigger_result_compare_regs
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hardware_trigger_input,
  input wire adc_ctrl_pkg::result_t sample_data,
  output logic [27:0] analog_input_select,
  output logic high_reference_select,
  output logic low_reference_select,
  output logic converter_power_down,
  output logic conversion_active_flag
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Engine
  // ----------------------------------------------------------------
  conv_if conv();

  conv_engine u_engine
  (
    .clk(clk),
    .reset(reset),
    .sample_data(sample_data),
    .conv(conv.engine)
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  channel_t channel_select;
  logic completion_flag;
  logic trigger_source_select;
  logic compare_enable;
  logic compare_greater_equal;
  logic [1:0] mode;
  logic [1:0] compare_value_high;
  logic [7:0] compare_value_low;
  logic [1:0] result_high_bits;
  logic [7:0] result_low_bits;
  logic result_lock;

  logic access;
  logic wr;
  logic rd;
  logic addr_hit;
  logic ten_bit;
  logic [1:0] wmode;
  logic [9:0] compare_bits;
  logic compare_true;
  logic store_ok;
  logic mode_change;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state so read data leaves a flip-flop
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign wmode = pwdata[`MODE_MSB:`MODE_LSB];
  assign ten_bit = (mode == `MODE_TEN_BIT); // see [RULE_20]

  always_comb
  begin
    case (paddr)
      `OFS_STATUS_CONTROL_ONE,
      `OFS_STATUS_CONTROL_TWO,
      `OFS_RESULT_HIGH,
      `OFS_RESULT_LOW,
      `OFS_COMPARE_VALUE_HIGH,
      `OFS_COMPARE_VALUE_LOW,
      `OFS_CONFIGURATION:
        addr_hit = 1'b1;
      default:
        addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pslverr <= 1'b0;
    else
      pslverr <= psel && penable && !pready && !addr_hit;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      prdata <= 32'h0000_0000;
    else if (psel && penable && !pready && (!pwrite || !addr_hit))
    begin
      case (paddr)
        `OFS_STATUS_CONTROL_ONE:
          prdata <= {24'h00_0000, completion_flag, 2'b00, channel_select};
        // Reserved low bits read as zero whatever software wrote
        `OFS_STATUS_CONTROL_TWO:
          prdata <= {24'h00_0000, conv.busy, trigger_source_select,
            compare_enable, compare_greater_equal, 4'h0};
        `OFS_RESULT_HIGH:
          prdata <= {30'h0000_0000, ten_bit ? result_high_bits : 2'b00}; // see [RULE_08]
        `OFS_RESULT_LOW:
          prdata <= {24'h00_0000, result_low_bits}; // see [RULE_09]
        `OFS_COMPARE_VALUE_HIGH:
          prdata <= {30'h0000_0000, compare_value_high};
        `OFS_COMPARE_VALUE_LOW:
          prdata <= {24'h00_0000, compare_value_low};
        `OFS_CONFIGURATION:
          prdata <= {28'h000_0000, mode, 2'b00};
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      channel_select <= `RST_CHANNEL;
    else if (wr && paddr == `OFS_STATUS_CONTROL_ONE)
      channel_select <= pwdata[4:0];
  end

  // Only bits 6..4 are stored; bits 1..0 are left for software to keep at zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      trigger_source_select <= 1'b0;
      compare_enable <= 1'b0;
      compare_greater_equal <= 1'b0;
    end
    else if (wr && paddr == `OFS_STATUS_CONTROL_TWO) // see [RULE_04]
    begin
      trigger_source_select <= pwdata[`BIT_TRIGGER_SOURCE];
      compare_enable <= pwdata[`BIT_COMPARE_ENABLE];
      compare_greater_equal <= pwdata[`BIT_COMPARE_GE];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      mode <= `RST_MODE;
    else if (wr && paddr == `OFS_CONFIGURATION)
      mode <= wmode;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      compare_value_high <= 2'b00;
      compare_value_low <= `RST_COMPARE;
    end
    else
    begin
      if (wr && paddr == `OFS_COMPARE_VALUE_HIGH)
        compare_value_high <= pwdata[1:0];
      if (wr && paddr == `OFS_COMPARE_VALUE_LOW)
        compare_value_low <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Hardware trigger
  // ----------------------------------------------------------------
  logic trig_meta;
  logic trig_s2;
  logic trig_s3;
  logic trig_level;
  logic trig_rise;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      trig_meta <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end
    else
    begin
      trig_meta <= hardware_trigger_input;
      trig_s2 <= trig_meta;
      trig_s3 <= trig_s2;
    end
  end

  // A level counts only once two stages agree, filtering single-cycle glitches
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      trig_level <= 1'b0;
    else if (trig_s2 == trig_s3)
      trig_level <= trig_s3; // see [RULE_21]
  end

  assign trig_rise = (trig_s2 == trig_s3) && trig_s3 && !trig_level; // see [RULE_21]

  // ----------------------------------------------------------------
  // Start and abort
  // ----------------------------------------------------------------
  logic sc1_write;

  assign sc1_write = wr && paddr == `OFS_STATUS_CONTROL_ONE;
  assign conv.abort = sc1_write; // see [RULE_19]
  // Trigger edges arriving mid-conversion are ignored rather than queued
  always_comb
  begin
    conv.start = 1'b0;
    if (sc1_write && !trigger_source_select && pwdata[4:0] != `CHANNEL_OFF)
      conv.start = 1'b1; // see [RULE_03] see [RULE_19]
    else if (trigger_source_select && trig_rise && !conv.busy
      && channel_select != `CHANNEL_OFF)
      conv.start = 1'b1; // see [RULE_03]
  end

  assign conversion_active_flag = conv.busy; // see [RULE_02]

  // ----------------------------------------------------------------
  // Compare and result storage
  // ----------------------------------------------------------------
  always_comb
  begin
    compare_bits = {compare_value_high, compare_value_low}; // see [RULE_15] see [RULE_17]
    if (!ten_bit)
      compare_bits = {2'b00, compare_value_low}; // see [RULE_16]
  end

  always_comb
  begin
    compare_true = 1'b0;
    if (ten_bit)
      compare_true = compare_greater_equal ? (conv.result >= compare_bits)
        : (conv.result < compare_bits); // see [RULE_06]
    else
      compare_true = compare_greater_equal ? (conv.result[7:0] >= compare_bits[7:0])
        : (conv.result[7:0] < compare_bits[7:0]); // see [RULE_06] see [RULE_17]
  end

  assign store_ok = !compare_enable || compare_true; // see [RULE_05] see [RULE_10]
  assign mode_change = wr && paddr == `OFS_CONFIGURATION && wmode != mode;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      result_high_bits <= 2'b00;
      result_low_bits <= 8'h00;
    end
    else if (mode_change)
    begin
      result_high_bits <= 2'b00; // see [RULE_14]
      result_low_bits <= 8'h00;
    end
    else if (conv.done && store_ok && !result_lock) // see [RULE_10] see [RULE_12]
    begin
      result_high_bits <= ten_bit ? conv.result[9:8] : 2'b00; // see [RULE_07] see [RULE_08]
      result_low_bits <= conv.result[7:0]; // see [RULE_09]
    end
  end

  // Lock is raised only in ten-bit mode, so eight-bit completions are never dropped by the lock
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      result_lock <= 1'b0;
    else if (mode_change || !ten_bit)
      result_lock <= 1'b0; // see [RULE_13] see [RULE_14]
    else if (rd && paddr == `OFS_RESULT_LOW)
      result_lock <= 1'b0; // see [RULE_11]
    else if (rd && paddr == `OFS_RESULT_HIGH)
      result_lock <= 1'b1; // see [RULE_11]
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      completion_flag <= 1'b0;
    else if (conv.done && store_ok)
      completion_flag <= 1'b1; // see [RULE_18]
    else if (sc1_write || (rd && paddr == `OFS_RESULT_LOW))
      completion_flag <= 1'b0; // see [RULE_18]
  end

  // ----------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 28; gi = gi + 1)
    begin : g_input
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          analog_input_select[gi] <= 1'b0;
        else
          analog_input_select[gi] <= (channel_select == 5'(gi)); // see [RULE_01]
      end
    end
  endgenerate

  // The reserved code selects nothing at all
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      high_reference_select <= 1'b0;
      low_reference_select <= 1'b0;
      converter_power_down <= 1'b1;
    end
    else
    begin
      high_reference_select <= (channel_select == `CHANNEL_REF_HIGH); // see [RULE_01]
      low_reference_select <= (channel_select == `CHANNEL_REF_LOW); // see [RULE_01]
      converter_power_down <= (channel_select == `CHANNEL_OFF); // see [RULE_01]
    end
  end
endmodule

// file: adc_regs_monitor.sv
// Checker on the top-level ports of the converter register block.
// Assumes one clock domain, the active-high reset and the constants header.
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module adc_regs_monitor
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [27:0] analog_input_select,
  input wire logic high_reference_select,
  input wire logic low_reference_select,
  input wire logic converter_power_down,
  input wire logic conversion_active_flag
);
  localparam int CONV = `CONV_CYCLES;
  logic wr1;
  logic trig_sel;
  logic [5:0] active_count;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  assign wr1 = psel && penable && pready && pwrite && paddr == `OFS_STATUS_CONTROL_ONE;

  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      trig_sel <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == `OFS_STATUS_CONTROL_TWO)
      trig_sel <= pwdata[6];
  end

  // Restarts on each control-one write, since that write aborts the conversion and may start a new one
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      active_count <= 6'h00;
    else if (wr1 || !conversion_active_flag)
      active_count <= 6'h00;
    else
      active_count <= active_count + 6'h01;
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence one_write_s;
    wr1;
  endsequence
  sequence access_wait_s;
    psel && penable && !pready;
  endsequence

  ready_after_wait_a: assert property (access_wait_s |=> pready)
    else $error("pready missing after access cycle");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  error_data_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error response carried data");
  upper_read_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  select_decode_a: assert property (one_write_s |-> ##2
    analog_input_select == (28'h1 << $past(pwdata[4:0], 2)))
    else $error("input select decode wrong");
  reference_decode_a: assert property (one_write_s |-> ##2
    {high_reference_select, low_reference_select, converter_power_down} ==
    {$past(pwdata[4:0], 2) == 5'h1d, $past(pwdata[4:0], 2) == 5'h1e,
    $past(pwdata[4:0], 2) == 5'h1f})
    else $error("reference decode wrong");
  start_on_write_a: assert property (one_write_s ##0
    (!trig_sel && pwdata[4:0] != 5'h1f) |=> conversion_active_flag)
    else $error("software start missing");
  abort_on_off_a: assert property (one_write_s ##0 (pwdata[4:0] == 5'h1f)
    |-> ##2 !conversion_active_flag)
    else $error("abort did not stop conversion");
  active_length_a: assert property ($fell(conversion_active_flag) && !$past(wr1)
    && !$past(wr1, 2) |-> active_count == CONV)
    else $error("conversion active length wrong");
  active_bound_a: assert property (active_count <= CONV)
    else $error("conversion active too long");
endmodule

// file: tb.sv
// Self-checking bench for the converter register block, with a model in integers.
// Assumes APB answers within a few cycles and a conversion of 25 cycles.
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module tb;
  import adc_ctrl_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hw_trig = 1'b0;
  result_t sample = 10'h000;
  logic [27:0] sel;
  logic ref_hi;
  logic ref_lo;
  logic pwr_dn;
  logic active;
  logic [31:0] q;
  logic e;
  int fail_count = 0;
  int checks = 0;
  int res, flag, lock, ten, en, ge, cvh, cvl, i;

  always #20 clk = ~clk;

  adc_trigger_result_compare_regs adc_trigger_result_compare_regs_inst
  (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hardware_trigger_input(hw_trig), .sample_data(sample), .analog_input_select(sel),
    .high_reference_select(ref_hi), .low_reference_select(ref_lo),
    .converter_power_down(pwr_dn), .conversion_active_flag(active)
  );

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      check("ready", 32'h1, 32'h0);
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check($sformatf("reg %h", a), exp, q);
  endtask

  task automatic wait_level(input logic lvl, input int limit);
    int n = 0;
    while (active !== lvl && n < limit)
    begin
      @(posedge clk);
      n++;
    end
    if (active !== lvl)
    begin
      check("active", 32'(lvl), 32'(active));
      conclude();
    end
  endtask

  // ------------------------------------------------------------
  // Model tasks
  // ------------------------------------------------------------
  task automatic convert(input int v, input bit hw);
    int r;
    int c;
    sample <= v[9:0];
    wr(`OFS_STATUS_CONTROL_ONE, 32'h5);
    flag = 0;
    if (hw)
    begin
      repeat (6) @(posedge clk);
      check("idle", 32'h0, {31'h0, active});
      hw_trig <= 1'b1;
    end
    wait_level(1'b1, 10);
    hw_trig <= 1'b0;
    if (hw)
      rd(`OFS_STATUS_CONTROL_TWO, 32'hc0);
    wait_level(1'b0, 40);
    r = ten ? v : v % 256;
    c = ten ? cvh * 256 + cvl : cvl;
    if (!en || (ge ? r >= c : r < c))
    begin
      flag = 1;
      if (!lock)
        res = r;
    end
  endtask

  task automatic rd_all(input bit hi, input bit lo);
    rd(`OFS_STATUS_CONTROL_ONE, flag * 128 + 5);
    if (hi)
      rd(`OFS_RESULT_HIGH, res / 256);
    if (hi && ten)
      lock = 1;
    if (lo)
      rd(`OFS_RESULT_LOW, res % 256);
    if (lo)
      lock = 0;
    if (lo)
      flag = 0;
  endtask

  task automatic set_mode(input int t);
    if (t != ten)
      res = 0;
    if (t != ten)
      lock = 0;
    ten = t;
    wr(`OFS_CONFIGURATION, t * 8);
    rd(`OFS_CONFIGURATION, t * 8);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h4098));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(`OFS_STATUS_CONTROL_ONE, 32'h1f);
    for (i = 4; i <= 20; i += 4)
      rd(12'(i), 32'h0);
    for (i = 0; i < 32; i++)
    begin
      wr(`OFS_STATUS_CONTROL_ONE, 32'(i));
      repeat (2) @(posedge clk);
      check("select", 32'(i < 28 ? 1 << i : 0), {4'h0, sel});
      check("refs", 32'(i == 29 ? 4 : i == 30 ? 2 : i == 31 ? 1 : 0),
        {29'h0, ref_hi, ref_lo, pwr_dn});
    end
    convert($urandom % 1024, 0);
    rd_all(1, 0);
    convert($urandom % 1024, 0);
    rd_all(0, 1);
    wr(`OFS_RESULT_LOW, 32'hff);
    rd_all(1, 1);
    set_mode(1);
    convert($urandom % 1024, 0);
    rd_all(1, 0);
    convert($urandom % 1024, 0);
    rd_all(0, 1);
    convert($urandom % 1024, 0);
    rd_all(1, 1);
    for (i = 0; i < 20; i++)
    begin
      set_mode($urandom % 2);
      en = $urandom % 2;
      ge = $urandom % 2;
      cvh = $urandom % 4;
      cvl = $urandom % 256;
      wr(`OFS_COMPARE_VALUE_HIGH, cvh);
      wr(`OFS_COMPARE_VALUE_LOW, cvl);
      wr(`OFS_STATUS_CONTROL_TWO, en * 32 + ge * 16);
      rd(`OFS_STATUS_CONTROL_TWO, en * 32 + ge * 16);
      rd(`OFS_COMPARE_VALUE_HIGH, cvh);
      rd(`OFS_COMPARE_VALUE_LOW, cvl);
      convert($urandom % 1024, 0);
      rd_all(1, 1);
    end
    en = 0;
    ge = 0;
    wr(`OFS_STATUS_CONTROL_TWO, 32'h40);
    convert($urandom % 1024, 1);
    rd_all(1, 1);
    wr(`OFS_STATUS_CONTROL_TWO, 32'h0);
    hw_trig <= 1'b1;
    repeat (8) @(posedge clk);
    check("ignored", 32'h0, {31'h0, active});
    hw_trig <= 1'b0;
    apb(12'h01c, 1'b0, 32'h0);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, q);
    wr(12'h01c, 32'hff);
    check("unmapped write error", 32'h1, {31'h0, e});
    conclude();
  end
endmodule

bind adc_trigger_result_compare_regs adc_regs_monitor adc_regs_monitor_inst
(
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .analog_input_select(analog_input_select), .high_reference_select(high_reference_select),
  .low_reference_select(low_reference_select), .converter_power_down(converter_power_down),
  .conversion_active_flag(conversion_active_flag)
);
